// *** logic/bse_defs.vh ***
// Constants, input vector layout and timing counts of the bistable block.
`ifndef BSE_DEFS_VH
`define BSE_DEFS_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define BSE_CLK_PERIOD_NS 100
`define BSE_TRIG_MIN_NS 20
`define BSE_JK_STABLE_NS 25
`define BSE_TRIG_MIN_CYC_RAW \
  ((`BSE_TRIG_MIN_NS + `BSE_CLK_PERIOD_NS - 1) / `BSE_CLK_PERIOD_NS)
`define BSE_TRIG_MIN_CYC \
  ((`BSE_TRIG_MIN_CYC_RAW < 1) ? 1 : `BSE_TRIG_MIN_CYC_RAW)

// ****************************************************************
// Element indices
// ****************************************************************
`define BSE_NUM_EL 5
`define BSE_EL_MS 0
`define BSE_EL_DUAL_A 1
`define BSE_EL_DUAL_B 2
`define BSE_EL_ET 3
`define BSE_EL_D 4
`define BSE_MS_MASK 5'h07

// ****************************************************************
// Layout of the synchronised pin vector
// ****************************************************************
`define BSE_PIN_W 32
`define BSE_POS_TRIG 0
`define BSE_POS_S1N 5
`define BSE_POS_S2N 10
`define BSE_POS_MS_J 15
`define BSE_POS_MS_K 18
`define BSE_POS_DU_J 21
`define BSE_POS_DU_K 23
`define BSE_POS_ET_J 25
`define BSE_POS_ET_K 28
`define BSE_POS_D 31
`define BSE_PIN_RST 32'h0000_7FE0

`endif

// *** logic/bse_bistables.v ***
// Master-slave, dual, edge-triggered JK and D bistable elements.
`timescale 1ns/10ps
`include "bse_defs.vh"

module bse_bistables
(
  input wire CLK_SYS_I,
  input wire RST_N_I,
  input wire MS_TRIG_I,
  input wire [2:0] MS_J_I,
  input wire [2:0] MS_K_I,
  input wire MS_S1_N_I,
  input wire MS_S2_N_I,
  output wire MS_Q_O,
  output wire MS_QN_O,
  input wire [1:0] DUAL_TRIG_I,
  input wire [1:0] DUAL_J_I,
  input wire [1:0] DUAL_K_I,
  input wire [1:0] DUAL_S1_N_I,
  input wire [1:0] DUAL_S2_N_I,
  output wire [1:0] DUAL_Q_O,
  output wire [1:0] DUAL_QN_O,
  input wire ET_TRIG_I,
  input wire [2:0] ET_J_I,
  input wire [2:0] ET_K_I,
  input wire ET_S1_N_I,
  input wire ET_S2_N_I,
  output wire ET_Q_O,
  output wire ET_QN_O,
  input wire D_TRIG_I,
  input wire D_DATA_I,
  input wire D_S1_N_I,
  input wire D_S2_N_I,
  output wire D_Q_O,
  output wire D_QN_O
);

  localparam NEL = `BSE_NUM_EL;
  localparam PW = `BSE_PIN_W;
  localparam MIN_CYC_INT = `BSE_TRIG_MIN_CYC;
  localparam [1:0] MIN_CYC = MIN_CYC_INT[1:0];

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // Every pin crosses into the system clock through three stages, and a
  // change is accepted only once stages two and three agree. All pins
  // share one pipe so J, K and trigger stay aligned to the cycle.
  // The price is four cycles of latency, and a pin must hold a level
  // for more than one cycle before it is seen at all.
  wire [PW-1:0] pin_raw;
  reg [PW-1:0] sync1_r;
  reg [PW-1:0] sync2_r;
  reg [PW-1:0] sync3_r;
  reg [PW-1:0] pin_r;
  reg [PW-1:0] pin_nxt;
  integer b;

  assign pin_raw = {D_DATA_I, ET_K_I, ET_J_I, DUAL_K_I, DUAL_J_I,
                    MS_K_I, MS_J_I,
                    D_S2_N_I, ET_S2_N_I, DUAL_S2_N_I, MS_S2_N_I,
                    D_S1_N_I, ET_S1_N_I, DUAL_S1_N_I, MS_S1_N_I,
                    D_TRIG_I, ET_TRIG_I, DUAL_TRIG_I, MS_TRIG_I};

  always @*
  begin
    pin_nxt = pin_r;
    for (b = 0; b < PW; b = b + 1)
    begin
      if (sync2_r[b] == sync3_r[b])
      begin
        pin_nxt[b] = sync3_r[b];
      end
    end
  end

  always @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      sync1_r <= `BSE_PIN_RST;
      sync2_r <= `BSE_PIN_RST;
      sync3_r <= `BSE_PIN_RST;
      pin_r <= `BSE_PIN_RST;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= pin_nxt;
    end
  end

  // ****************************************************************
  // Effective J and K of each element
  // ****************************************************************
  wire [NEL-1:0] trig;
  wire [NEL-1:0] s1_n;
  wire [NEL-1:0] s2_n;
  wire [NEL-1:0] j_eff;
  wire [NEL-1:0] k_eff;
  wire [2:0] ms_j;
  wire [2:0] ms_k;
  wire [1:0] du_j;
  wire [1:0] du_k;
  wire [2:0] et_j;
  wire [2:0] et_k;
  wire d_in;

  assign trig = pin_r[`BSE_POS_TRIG +: NEL];
  assign s1_n = pin_r[`BSE_POS_S1N +: NEL];
  assign s2_n = pin_r[`BSE_POS_S2N +: NEL];
  assign ms_j = pin_r[`BSE_POS_MS_J +: 3];
  assign ms_k = pin_r[`BSE_POS_MS_K +: 3];
  assign du_j = pin_r[`BSE_POS_DU_J +: 2];
  assign du_k = pin_r[`BSE_POS_DU_K +: 2];
  assign et_j = pin_r[`BSE_POS_ET_J +: 3];
  assign et_k = pin_r[`BSE_POS_ET_K +: 3];
  assign d_in = pin_r[`BSE_POS_D];

  assign j_eff[`BSE_EL_MS] = &ms_j;
  assign k_eff[`BSE_EL_MS] = &ms_k;
  assign j_eff[`BSE_EL_DUAL_A] = du_j[0];
  assign k_eff[`BSE_EL_DUAL_A] = du_k[0];
  assign j_eff[`BSE_EL_DUAL_B] = du_j[1];
  assign k_eff[`BSE_EL_DUAL_B] = du_k[1];
  assign j_eff[`BSE_EL_ET] = et_j[0] & et_j[1] & ~et_j[2];
  assign k_eff[`BSE_EL_ET] = et_k[0] & et_k[1] & ~et_k[2];
  // The D element is a JK element whose K is the inverse of its J.
  assign j_eff[`BSE_EL_D] = d_in;
  assign k_eff[`BSE_EL_D] = ~d_in;

  // ****************************************************************
  // Trigger edges
  // ****************************************************************
  // Edges come from the filtered trigger, so a bounce shorter than the
  // filter never reaches an element as a false edge.
  reg [NEL-1:0] trig_d_r;
  wire [NEL-1:0] rise;
  wire [NEL-1:0] fall;

  assign rise = trig & ~trig_d_r;
  assign fall = ~trig & trig_d_r;

  always @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      trig_d_r <= {NEL{1'b0}};
    end
    else
    begin
      trig_d_r <= trig;
    end
  end

  // ****************************************************************
  // Bistable elements
  // ****************************************************************
  wire [NEL-1:0] q1;
  wire [NEL-1:0] q2;

  genvar g;
  generate
    for (g = 0; g < NEL; g = g + 1)
    begin : el
      localparam IS_MS = (`BSE_MS_MASK >> g) & 1;
      reg q_r;
      reg q_nxt;
      reg m_r;
      reg m_nxt;
      reg [1:0] cnt_r;
      reg [1:0] cnt_nxt;
      reg q1_r;
      reg q1_nxt;
      reg q2_r;
      reg q2_nxt;
      wire f1;
      wire f2;
      wire jk_val;

      assign f1 = ~s1_n[g];
      assign f2 = ~s2_n[g];
      // Hold, set, clear, or invert the stored state.
      assign jk_val = (j_eff[g] & ~q_r) | (~k_eff[g] & q_r);

      always @*
      begin
        q_nxt = q_r;
        m_nxt = m_r;
        cnt_nxt = cnt_r;
        if (f1 | f2)
        begin
          // Forcing overrides any trigger; both low keeps the old state.
          if (f1 & ~f2)
          begin
            q_nxt = 1'b0;
          end
          else if (f2 & ~f1)
          begin
            q_nxt = 1'b1;
          end
          m_nxt = q_nxt;
          cnt_nxt = 2'b00;
        end
        else if (IS_MS != 0)
        begin
          // Slave is frozen while trigger is high; master follows J/K,
          // so late changes during the pulse are taken up.
          if (trig[g])
          begin
            m_nxt = jk_val;
            if (cnt_r != 2'b11)
            begin
              cnt_nxt = cnt_r + 2'b01;
            end
          end
          else
          begin
            cnt_nxt = 2'b00;
          end
          // Gates closed at trailing edge, then master goes to slave.
          if (fall[g] && cnt_r >= MIN_CYC)
          begin
            q_nxt = m_r;
          end
        end
        else
        begin
          // Only the rising edge samples; a held-high trigger locks out J/K.
          if (rise[g])
          begin
            q_nxt = jk_val;
          end
        end
      end

      // Both-low forcing acts on the outputs only, so the stored state survives a
      // both-low period and returns once the direct inputs are released.
      always @*
      begin
        case ({f1, f2})
          2'b11:
          begin
            q1_nxt = 1'b1;
            q2_nxt = 1'b1;
          end
          2'b10:
          begin
            q1_nxt = 1'b0;
            q2_nxt = 1'b1;
          end
          2'b01:
          begin
            q1_nxt = 1'b1;
            q2_nxt = 1'b0;
          end
          default:
          begin
            q1_nxt = q_nxt;
            q2_nxt = ~q_nxt;
          end
        endcase
      end

      always @(posedge CLK_SYS_I)
      begin
        if (!RST_N_I)
        begin
          q_r <= 1'b0;
          m_r <= 1'b0;
          cnt_r <= 2'b00;
          q1_r <= 1'b0;
          q2_r <= 1'b1;
        end
        else
        begin
          q_r <= q_nxt;
          m_r <= m_nxt;
          cnt_r <= cnt_nxt;
          q1_r <= q1_nxt;
          q2_r <= q2_nxt;
        end
      end

      assign q1[g] = q1_r;
      assign q2[g] = q2_r;
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign MS_Q_O = q1[`BSE_EL_MS];
  assign MS_QN_O = q2[`BSE_EL_MS];
  assign DUAL_Q_O = {q1[`BSE_EL_DUAL_B], q1[`BSE_EL_DUAL_A]};
  assign DUAL_QN_O = {q2[`BSE_EL_DUAL_B], q2[`BSE_EL_DUAL_A]};
  assign ET_Q_O = q1[`BSE_EL_ET];
  assign ET_QN_O = q2[`BSE_EL_ET];
  assign D_Q_O = q1[`BSE_EL_D];
  assign D_QN_O = q2[`BSE_EL_D];

endmodule // bse_bistables

// *** testbench/bse_bistables_properties.sv ***
// Port-level assertions of the bistable block.
`timescale 1ns/10ps
module bse_bistables_properties
(
  input wire CLK_SYS_I,
  input wire RST_N_I,
  input wire MS_TRIG_I,
  input wire [2:0] MS_J_I,
  input wire [2:0] MS_K_I,
  input wire MS_S1_N_I,
  input wire MS_S2_N_I,
  input wire MS_Q_O,
  input wire MS_QN_O,
  input wire ET_TRIG_I,
  input wire [2:0] ET_J_I,
  input wire [2:0] ET_K_I,
  input wire ET_S1_N_I,
  input wire ET_S2_N_I,
  input wire ET_Q_O,
  input wire ET_QN_O,
  input wire D_TRIG_I,
  input wire D_DATA_I,
  input wire D_S1_N_I,
  input wire D_S2_N_I,
  input wire D_Q_O,
  input wire D_QN_O
);
  // ****
  // Properties
  // ****
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  wire ms_f = MS_S1_N_I & MS_S2_N_I;
  wire et_f = ET_S1_N_I & ET_S2_N_I;
  wire d_f = D_S1_N_I & D_S2_N_I;
  wire et_j = ET_J_I[0] & ET_J_I[1] & ~ET_J_I[2];
  wire et_k = ET_K_I[0] & ET_K_I[1] & ~ET_K_I[2];
  function automatic logic nxt(logic j, logic k, logic q);
    return (j & ~q) | (~k & q);
  endfunction
  // Inputs must be steady across the whole window, as the pins pass a
  // synchroniser before they act. Forcing must have been off for three
  // more cycles, so a released direct input has settled on the outputs.
  sequence s_ms_fall;
    ms_f[*3] ##1
    (ms_f && $stable({MS_J_I, MS_K_I}) && MS_TRIG_I)[*3] ##1
    (ms_f && $stable({MS_J_I, MS_K_I}) && !MS_TRIG_I)[*6];
  endsequence
  sequence s_et_rise;
    et_f[*3] ##1
    (et_f && $stable({ET_J_I, ET_K_I}) && !ET_TRIG_I)[*3] ##1
    (et_f && $stable({ET_J_I, ET_K_I}) && ET_TRIG_I)[*6];
  endsequence
  sequence s_d_rise;
    d_f[*3] ##1
    (d_f && $stable(D_DATA_I) && !D_TRIG_I)[*3] ##1
    (d_f && $stable(D_DATA_I) && D_TRIG_I)[*6];
  endsequence
  AST_RST_VAL: assert property (disable iff (1'b0)
    !RST_N_I |=> !MS_Q_O && MS_QN_O && !ET_Q_O && ET_QN_O && !D_Q_O)
    else $error("outputs not at reset level");
  AST_MS_TRIG: assert property (s_ms_fall |->
    MS_Q_O == nxt(&MS_J_I, &MS_K_I, $past(MS_Q_O, 6)))
    else $error("master-slave state wrong after trigger");
  AST_ET_EDGE: assert property (s_et_rise |->
    ET_Q_O == nxt(et_j, et_k, $past(ET_Q_O, 6)))
    else $error("edge element state wrong after trigger");
  AST_D_EDGE: assert property (s_d_rise |-> D_Q_O == D_DATA_I)
    else $error("data element did not take its input");
  AST_MS_S1_FORCE: assert property (
    (!MS_S1_N_I && MS_S2_N_I)[*6] |-> !MS_Q_O && MS_QN_O)
    else $error("first direct input did not clear");
  AST_ET_BOTH_FORCE: assert property (
    (!ET_S1_N_I && !ET_S2_N_I)[*6] |-> ET_Q_O && ET_QN_O)
    else $error("both direct inputs did not drive both high");
  AST_D_S2_FORCE: assert property (
    (D_S1_N_I && !D_S2_N_I)[*6] |-> D_Q_O && !D_QN_O)
    else $error("second direct input did not set");
  AST_MS_COMPL: assert property (MS_Q_O == MS_QN_O |-> MS_Q_O)
    else $error("master-slave outputs both low");
  AST_ET_COMPL: assert property (ET_Q_O || ET_QN_O)
    else $error("edge element outputs both low");
endmodule // bse_bistables_properties

bind bse_bistables bse_bistables_properties u_prop (.*);

// *** testbench/bse_feedback_model.sv ***
// Surrounding logic that can close the data element feedback loop.
`timescale 1ns/10ps
module bse_feedback_model
(
  input wire clk_i,
  input wire fb_en_i,
  input wire qn_i,
  input wire data_i,
  output wire data_o
);
  // ****
  // Feedback path
  // ****
  // A register in the loop keeps data steady past the sampling edge.
  logic qn_r = 1'b0;
  always @(posedge clk_i)
    qn_r <= qn_i;
  assign data_o = fb_en_i ? qn_r : data_i;
endmodule // bse_feedback_model

// *** testbench/bse_bistables_bench.sv ***
// Self-checking bench of the bistable block.
`timescale 1ns/10ps
module bse_bistables_bench;
  // ****
  // Stimulus and checks
  // ****
  logic clk_sys = 0, rst_n = 0, s1n = 1, s2n = 1, fb = 0;
  logic [4:0] trg = 0;
  logic [2:0] j = 0, k = 0;
  wire dd, msq, msqn, etq, etqn, dq, dqn;
  wire [1:0] duq, duqn;
  int error_cnt = 0, checked = 0;
  // Rows: J pins, K pins, then master-slave, edge, dual and data results.
  logic [9:0] rows [7] = '{10'b1110001011, 10'b0110001111,
    10'b0001110100, 10'b1111111111, 10'b0110111001, 10'b0000111000,
    10'b1111001011};
  always #50 clk_sys = ~clk_sys;
  bse_bistables u_dut (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n),
    .MS_TRIG_I(trg[0]), .MS_J_I(j), .MS_K_I(k), .MS_S1_N_I(s1n),
    .MS_S2_N_I(s2n), .MS_Q_O(msq), .MS_QN_O(msqn),
    .DUAL_TRIG_I(trg[2:1]), .DUAL_J_I({2{j[0]}}), .DUAL_K_I({2{k[0]}}),
    .DUAL_S1_N_I({2{s1n}}), .DUAL_S2_N_I({2{s2n}}), .DUAL_Q_O(duq),
    .DUAL_QN_O(duqn), .ET_TRIG_I(trg[3]), .ET_J_I(j), .ET_K_I(k),
    .ET_S1_N_I(s1n), .ET_S2_N_I(s2n), .ET_Q_O(etq), .ET_QN_O(etqn),
    .D_TRIG_I(trg[4]), .D_DATA_I(dd), .D_S1_N_I(s1n), .D_S2_N_I(s2n),
    .D_Q_O(dq), .D_QN_O(dqn));
  bse_feedback_model u_fb (.clk_i(clk_sys), .fb_en_i(fb), .qn_i(dqn),
    .data_i(j[0]), .data_o(dd));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [1:0] e,
    input logic [1:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_all(input logic [4:0] e);
    chk("ms", {e[4], ~e[4]}, {msq, msqn});
    chk("et", {e[3], ~e[3]}, {etq, etqn});
    chk("du1", {e[2], ~e[2]}, {duq[1], duqn[1]});
    chk("du0", {e[1], ~e[1]}, {duq[0], duqn[0]});
    chk("d", {e[0], ~e[0]}, {dq, dqn});
  endtask
  // Each phase lasts at least the four-cycle synchroniser latency.
  task automatic pulse(input logic [4:0] m);
    cyc(4);
    trg = m;
    cyc(8);
    trg = 0;
    cyc(8);
  endtask
  task automatic conclude;
    $display("Checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    cyc(12);
    chk_all(5'b00000);
    rst_n = 1;
    $display("test reset done");
    foreach (rows[i])
    begin
      {j, k} = rows[i][9:4];
      pulse(5'b11111);
      chk_all({rows[i][3:1], rows[i][1:0]});
    end
    $display("test table done");
    {j, k} = 6'b000000;
    cyc(4);
    trg = 5'b11111;
    cyc(6);
    {j, k} = 6'b011111;
    cyc(4);
    trg = 0;
    cyc(8);
    chk_all(5'b00000);
    $display("test change while high done");
    {j, k} = 6'b111111;
    pulse(5'b00010);
    chk_all(5'b00010);
    $display("test dual independence done");
    {s1n, s2n} = 2'b00;
    cyc(8);
    chk("force", 2'b11, {msq & etq & dq & (&duq),
      msqn & etqn & dqn & (&duqn)});
    for (int f = 1; f < 4; f++)
    begin
      {s1n, s2n} = f[1:0];
      cyc(8);
      chk_all({5{f[1]}});
    end
    $display("test direct inputs done");
    fb = 1;
    pulse(5'b10000);
    chk("tgl", 2'b01, {dq, dqn});
    pulse(5'b10000);
    chk("tgl", 2'b10, {dq, dqn});
    $display("test toggle done");
    rst_n = 0;
    cyc(2);
    chk_all(5'b00000);
    rst_n = 1;
    cyc(6);
    chk_all(5'b00000);
    $display("test mid-run reset done");
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule // bse_bistables_bench
